// ==== hw/mac_mgmt_consts.svh ====
// Purpose: Offsets, field masks, reset values and counts of the MAC management register bank
// Assumes: Register indices are multiplied by four to form APB byte addresses
// Notes:   Definitions only
`ifndef MAC_MGMT_CONSTS_SVH
`define MAC_MGMT_CONSTS_SVH

// Register indices (byte address = index * 4)
`define IDX_MGMT_CMD 8'h3b
`define IDX_WDATA_LO 8'h3c
`define IDX_WDATA_HI 8'h3d
`define IDX_REG_SEL 8'h3e
`define IDX_UNIT_SEL 8'h3f
`define IDX_POLL 8'h40
`define IDX_FRESET 8'h41
`define IDX_TLB_LO 8'h42
`define IDX_TLB_HI 8'h43
`define IDX_RDATA 8'h50
`define IDX_STATUS 8'h51

// Writable field masks and reset values
`define MASK_ADDR5 8'h1f
`define MASK_FRESET 8'h3f
`define MASK_TLB_LO 8'he0
`define MASK_TLB_HI 8'h1f
`define MASK_CMD_KEEP 8'h3f
`define RST_FRESET 8'h20
`define RST_BYTE 8'h00

// Bit positions
`define CMD_WRITE_BIT 7
`define CMD_READ_BIT 6
`define FR_GLOBAL 5
`define FR_TX_FUNC 4
`define FR_RX_FUNC 3
`define FR_TX_CTRL 2
`define FR_RX_CTRL 1
`define FR_MGMT 0

// Poll prescaler: one unit is 256 system clocks
`define POLL_UNIT_MAX 8'hff

// Management frame layout
`define FRAME_PREAMBLE 32'hffff_ffff
`define FRAME_START 2'h1
`define FRAME_OP_WR 2'h1
`define FRAME_OP_RD 2'h2
`define FRAME_TA_WR 2'h2
`define FRAME_LAST_BIT 7'h3f
`define FRAME_TA_BIT 7'h2e
`define FRAME_DATA_BIT 7'h30

// Half periods of the management clock per divisor code
`define MDC_HALF_4 4'h2
`define MDC_HALF_6 4'h3
`define MDC_HALF_8 4'h4
`define MDC_HALF_10 4'h5
`define MDC_HALF_14 4'h7
`define MDC_HALF_20 4'ha
`define MDC_HALF_28 4'he

`endif

// ==== hw/mac_mgmt_pkg.sv ====
// Purpose: Types shared by the MAC management register bank
// Assumes: Constants live in mac_mgmt_consts.svh
// Notes:   No imports are used; refer as mac_mgmt_pkg::name
package mac_mgmt_pkg;

  typedef enum logic {
    MG_IDLE,
    MG_RUN
  } mgmt_state_t;

endpackage

// ==== hw/mac_mgmt_poll_reset_regs.sv ====
// Purpose: MAC register bank for PHY management, transmit polling and function resets
// Assumes: APB slave with zero wait states; pclk at 10 MHz
// Notes:   Holds a compact serial management engine for the external PHY
// Operation
// - Two write-data bytes form one 16-bit word
// - Write word is shifted out on management data
// - High byte bit 7 is word bit 15
// - 5-bit unit address selects the PHY
// - 5-bit register address selects PHY register
// - Poll unit is system clock over 256
// - Writing poll period triggers immediate ownership check
// - Recheck every unit times period value
// - Period zero disables polling and new frames
// - Frame in progress completes before stopping
// - Reset bits never clear by themselves
// - Global reset bit holds all functions, resets high
// - Bits 4 and 2 reset transmit paths
// - Bits 3 and 1 reset receive paths
// - Bit 0 resets the management function
// - Lower bound is 16 bits, low bit 0 lsb
// - Write command starts PHY write when idle
// - Read command fetches PHY word when idle
// - Divisor code selects management clock divide ratio
`timescale 1ns/1ps
`include "mac_mgmt_consts.svh"

module mac_mgmt_poll_reset_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic tx_frame_active,
  output logic tx_poll_check,
  output logic tx_new_frame_enable,
  output logic tx_stopped,
  output logic [15:0] tx_lower_bound,
  output logic tx_function_reset,
  output logic rx_function_reset,
  output logic tx_control_reset,
  output logic rx_control_reset,
  output logic mgmt_function_reset
);

  logic [7:0] wdata_lo_q, wdata_hi_q, reg_sel_q, unit_sel_q, poll_q, freset_q;
  logic [7:0] tlb_lo_q, tlb_hi_q, cmd_q;
  logic [15:0] rdata_q;
  logic [31:0] prdata_q;
  logic [7:0] idx;
  logic mapped, wr_en, setup;
  logic [15:0] phy_write_data;
  logic start_wr, start_rd, busy;
  mac_mgmt_pkg::mgmt_state_t state_q;
  logic [63:0] shreg_q;
  logic [6:0] bitcnt_q;
  logic is_rd_q, mdc_q, mdc_tick;
  logic [3:0] div_cnt_q, half_d;
  logic [7:0] pre_q, units_q;
  logic unit_tick, poll_wr, poll_q_r;
  logic [8:0] gap_q;

  // Zero wait states keep the master simple; errors flag only unmapped words
  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_comb begin
    unique case (idx)
      `IDX_MGMT_CMD, `IDX_WDATA_LO, `IDX_WDATA_HI, `IDX_REG_SEL, `IDX_UNIT_SEL,
      `IDX_POLL, `IDX_FRESET, `IDX_TLB_LO, `IDX_TLB_HI, `IDX_RDATA,
      `IDX_STATUS: mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
      default: mapped = 1'b0;
    endcase
  end

  // Read data is latched in the setup phase so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      unique case (idx)
        `IDX_MGMT_CMD: prdata_q[7:0] <= cmd_q & `MASK_CMD_KEEP;
        `IDX_WDATA_LO: prdata_q[7:0] <= wdata_lo_q;
        `IDX_WDATA_HI: prdata_q[7:0] <= wdata_hi_q;
        `IDX_REG_SEL: prdata_q[7:0] <= reg_sel_q & `MASK_ADDR5;
        `IDX_UNIT_SEL: prdata_q[7:0] <= unit_sel_q & `MASK_ADDR5;
        `IDX_POLL: prdata_q[7:0] <= poll_q;
        `IDX_FRESET: prdata_q[7:0] <= freset_q & `MASK_FRESET;
        `IDX_TLB_LO: prdata_q[7:0] <= tlb_lo_q & `MASK_TLB_LO;
        `IDX_TLB_HI: prdata_q[7:0] <= tlb_hi_q & `MASK_TLB_HI;
        `IDX_RDATA: prdata_q[15:0] <= rdata_q;
        `IDX_STATUS: prdata_q[1:0] <= {tx_new_frame_enable, busy};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Plain data and address registers; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_lo_q <= `RST_BYTE;
      wdata_hi_q <= `RST_BYTE;
      reg_sel_q <= `RST_BYTE;
      unit_sel_q <= `RST_BYTE;
      tlb_lo_q <= `RST_BYTE;
      tlb_hi_q <= `RST_BYTE;
    end else if (wr_en) begin
      if (idx == `IDX_WDATA_LO) wdata_lo_q <= pwdata[7:0];
      if (idx == `IDX_WDATA_HI) wdata_hi_q <= pwdata[7:0];
      if (idx == `IDX_REG_SEL) reg_sel_q <= pwdata[7:0] & `MASK_ADDR5;
      if (idx == `IDX_UNIT_SEL) unit_sel_q <= pwdata[7:0] & `MASK_ADDR5;
      if (idx == `IDX_TLB_LO) tlb_lo_q <= pwdata[7:0] & `MASK_TLB_LO;
      if (idx == `IDX_TLB_HI) tlb_hi_q <= pwdata[7:0] & `MASK_TLB_HI;
    end
  end

  assign phy_write_data = {wdata_hi_q, wdata_lo_q};
  assign tx_lower_bound = {tlb_hi_q, tlb_lo_q};

  // Reset bits change only on software writes; the global bit comes up set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freset_q <= `RST_FRESET;
    end else if (wr_en && idx == `IDX_FRESET) begin
      freset_q <= pwdata[7:0] & `MASK_FRESET;
    end
  end

  assign tx_function_reset = freset_q[`FR_GLOBAL] | freset_q[`FR_TX_FUNC];
  assign tx_control_reset = freset_q[`FR_GLOBAL] | freset_q[`FR_TX_CTRL];
  assign rx_function_reset = freset_q[`FR_GLOBAL] | freset_q[`FR_RX_FUNC];
  assign rx_control_reset = freset_q[`FR_GLOBAL] | freset_q[`FR_RX_CTRL];
  assign mgmt_function_reset = freset_q[`FR_GLOBAL] | freset_q[`FR_MGMT];

  // Command bits self-clear, so every write of a one is a fresh rising edge
  assign busy = (state_q == mac_mgmt_pkg::MG_RUN);
  assign start_wr = wr_en && idx == `IDX_MGMT_CMD && pwdata[`CMD_WRITE_BIT]
                    && !busy && !mgmt_function_reset;
  assign start_rd = wr_en && idx == `IDX_MGMT_CMD && pwdata[`CMD_READ_BIT]
                    && !pwdata[`CMD_WRITE_BIT] && !busy && !mgmt_function_reset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= `RST_BYTE;
    end else if (wr_en && idx == `IDX_MGMT_CMD) begin
      cmd_q <= pwdata[7:0] & `MASK_CMD_KEEP;
    end
  end

  // Divisor code to half period of the management clock
  always_comb begin
    unique case (cmd_q[2:0])
      3'h0, 3'h1: half_d = `MDC_HALF_4;
      3'h2: half_d = `MDC_HALF_6;
      3'h3: half_d = `MDC_HALF_8;
      3'h4: half_d = `MDC_HALF_10;
      3'h5: half_d = `MDC_HALF_14;
      3'h6: half_d = `MDC_HALF_20;
      default: half_d = `MDC_HALF_28;
    endcase
  end

  assign mdc_tick = busy && (div_cnt_q == half_d - 4'h1);

  // Clock divider runs only during a frame so each frame starts with a full low phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 4'h0;
      mdc_q <= 1'b0;
    end else if (!busy || mgmt_function_reset) begin
      div_cnt_q <= 4'h0;
      mdc_q <= 1'b0;
    end else if (mdc_tick) begin
      div_cnt_q <= 4'h0;
      mdc_q <= !mdc_q;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Frame engine: shift on the falling edge, sample read data on the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= mac_mgmt_pkg::MG_IDLE;
      shreg_q <= 64'h0;
      bitcnt_q <= 7'h0;
      is_rd_q <= 1'b0;
    end else if (mgmt_function_reset) begin
      state_q <= mac_mgmt_pkg::MG_IDLE;
      bitcnt_q <= 7'h0;
    end else if (start_wr || start_rd) begin
      state_q <= mac_mgmt_pkg::MG_RUN;
      shreg_q <= {`FRAME_PREAMBLE, `FRAME_START,
                  start_wr ? `FRAME_OP_WR : `FRAME_OP_RD,
                  unit_sel_q[4:0], reg_sel_q[4:0], `FRAME_TA_WR,
                  phy_write_data};
      bitcnt_q <= 7'h0;
      is_rd_q <= start_rd;
    end else if (mdc_tick && mdc_q) begin
      if (bitcnt_q == `FRAME_LAST_BIT) begin
        state_q <= mac_mgmt_pkg::MG_IDLE;
      end
      bitcnt_q <= bitcnt_q + 7'h1;
      shreg_q <= {shreg_q[62:0], 1'b0};
    end
  end

  // Read word is assembled msb first during the last sixteen clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 16'h0000;
    end else if (busy && is_rd_q && mdc_tick && !mdc_q && bitcnt_q >= `FRAME_DATA_BIT) begin
      rdata_q <= {rdata_q[14:0], mdio_in};
    end
  end

  // Release the data pin from turnaround onward in a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_out <= 1'b0;
      mdio_oe_n <= 1'b1;
      mdc <= 1'b0;
    end else begin
      mdc <= mdc_q;
      mdio_out <= busy && shreg_q[63];
      mdio_oe_n <= !busy || (is_rd_q && bitcnt_q >= `FRAME_TA_BIT);
    end
  end

  // Poll period register
  assign poll_wr = wr_en && idx == `IDX_POLL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_q <= `RST_BYTE;
    end else if (poll_wr) begin
      poll_q <= pwdata[7:0];
    end
  end

  assign unit_tick = (pre_q == `POLL_UNIT_MAX);

  // Prescaler restarts on every period write so the interval starts fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 8'h00;
    end else if (poll_wr || poll_q == 8'h00) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Interval counter and check pulse; a zero period silences both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units_q <= 8'h00;
      tx_poll_check <= 1'b0;
    end else if (poll_wr) begin
      units_q <= pwdata[7:0];
      tx_poll_check <= (pwdata[7:0] != 8'h00) && !tx_function_reset;
    end else if (poll_q != 8'h00 && unit_tick) begin
      if (units_q <= 8'h01) begin
        units_q <= poll_q;
        tx_poll_check <= !tx_function_reset;
      end else begin
        units_q <= units_q - 8'h01;
        tx_poll_check <= 1'b0;
      end
    end else begin
      tx_poll_check <= 1'b0;
    end
  end

  // A running frame is never cut; the transmitter only blocks new starts
  assign tx_new_frame_enable = (poll_q != 8'h00);
  assign tx_stopped = !tx_new_frame_enable && !tx_frame_active;

  // Cycles since the last unit tick, for checking the prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 9'h000;
      poll_q_r <= 1'b0;
    end else begin
      gap_q <= (unit_tick || poll_wr) ? 9'h000 : gap_q + 9'h001;
      poll_q_r <= poll_wr;
    end
  end

  property p_unit;
    @(posedge pclk) disable iff (!presetn)
    unit_tick && !poll_q_r |-> gap_q == 9'h0ff;
  endproperty
  a_unit: assert property (p_unit) else $error("poll unit not 256 clocks");

  property p_write_check;
    @(posedge pclk) disable iff (!presetn)
    poll_wr && pwdata[7:0] != 8'h00 && !tx_function_reset |=> tx_poll_check;
  endproperty
  a_write_check: assert property (p_write_check) else $error("no check after write");

  property p_zero_off;
    @(posedge pclk) disable iff (!presetn)
    poll_q == 8'h00 && !poll_wr |=> !tx_poll_check && !tx_new_frame_enable;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("polling active at zero");

  property p_frame_finish;
    @(posedge pclk) disable iff (!presetn)
    tx_frame_active |-> !tx_stopped;
  endproperty
  a_frame_finish: assert property (p_frame_finish) else $error("stopped mid frame");

  property p_no_self_clear;
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && idx == `IDX_FRESET) |=> $stable(freset_q);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("reset bits moved");

  property p_global;
    @(posedge pclk) disable iff (!presetn)
    freset_q[`FR_GLOBAL] |-> tx_function_reset && rx_function_reset && tx_control_reset
                             && rx_control_reset && mgmt_function_reset;
  endproperty
  a_global: assert property (p_global) else $error("global reset not applied");

  property p_mgmt_reset;
    @(posedge pclk) disable iff (!presetn)
    mgmt_function_reset |=> !busy ##1 mdio_oe_n;
  endproperty
  a_mgmt_reset: assert property (p_mgmt_reset) else $error("engine ran in reset");

  property p_write_frame;
    @(posedge pclk) disable iff (!presetn)
    start_wr |=> busy && shreg_q[15:0] == $past(phy_write_data)
                 && shreg_q[27:18] == $past({unit_sel_q[4:0], reg_sel_q[4:0]});
  endproperty
  a_write_frame: assert property (p_write_frame) else $error("write frame wrong");

  property p_read_release;
    @(posedge pclk) disable iff (!presetn)
    busy && is_rd_q && bitcnt_q >= `FRAME_TA_BIT |=> mdio_oe_n;
  endproperty
  a_read_release: assert property (p_read_release) else $error("pin driven in read");

  property p_mdc_div;
    @(posedge pclk) disable iff (!presetn)
    busy && cmd_q[2:0] == 3'h0 && $rose(mdc_q) && !mgmt_function_reset
      |-> ##2 (!mdc_q || !busy);
  endproperty
  a_mdc_div: assert property (p_mdc_div) else $error("divide by four wrong");

endmodule

// ==== dv/phy_model.sv ====
// Purpose: Behavioural PHY on the management link
// Assumes: A frame is 64 rising mdc edges counted from reset
// Notes: A released line is captured as zero in frame
`timescale 1ns/1ps
module phy_model (
  input wire logic presetn,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic [15:0] rd_word,
  output logic drv_en,
  output logic drv_d,
  output logic [63:0] frame,
  output int frames
);
  int cnt;
  logic rd_q;
  // Capture on rising mdc, the device launches on falling mdc
  always @(posedge mdc or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      frames <= 0;
      frame <= '0;
    end else begin
      frame <= {frame[62:0], mdio_out & !mdio_oe_n};
      cnt <= (cnt == 63) ? 0 : cnt + 1;
      if (cnt == 63) frames <= frames + 1;
    end
  end
  // Answer a read msb first from bit 48, then release for the pull-up
  always @(negedge mdc or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
      drv_en <= 1'b0;
      drv_d <= 1'b0;
    end else begin
      if (cnt == 36) rd_q <= (frame[1:0] == 2'b10);
      drv_en <= rd_q && cnt >= 48;
      if (rd_q && cnt >= 48) drv_d <= rd_word[63-cnt];
    end
  end
endmodule

// ==== dv/tb_mac_mgmt_poll_reset_regs.sv ====
// Purpose: Self-checking bench for the MAC management register bank
// Assumes: Zero-wait APB slave, PHY model on the management link
// Notes: Reads note their expected data in a queue checked by a monitor
`timescale 1ns/1ps
`include "mac_mgmt_consts.svh"
module tb_mac_mgmt_poll_reset_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mdc, mdio_in, mdio_out;
  logic mdio_oe_n, tx_frame_active, tx_poll_check, tx_new_frame_enable, tx_stopped;
  logic drv_en, drv_d, mdc_q, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] tx_lower_bound, rd_word, d;
  logic [4:0] fres, u, r;
  logic [63:0] frame;
  logic [32:0] expq[$];
  logic [32:0] note;
  int frames, errors, samples_checked, cyc, npulse, last_pulse, gap, mcnt, mper, n0, k;
  int per[8] = '{4, 4, 6, 8, 10, 14, 20, 28};

  mac_mgmt_poll_reset_regs mac_mgmt_poll_reset_regs_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .tx_frame_active(tx_frame_active),
    .tx_poll_check(tx_poll_check), .tx_new_frame_enable(tx_new_frame_enable),
    .tx_stopped(tx_stopped), .tx_lower_bound(tx_lower_bound),
    .tx_function_reset(fres[4]), .rx_function_reset(fres[3]), .tx_control_reset(fres[2]),
    .rx_control_reset(fres[1]), .mgmt_function_reset(fres[0]));
  phy_model phy_model_inst (.presetn(presetn), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .rd_word(rd_word), .drv_en(drv_en), .drv_d(drv_d),
    .frame(frame), .frames(frames));

  // Wire level of the shared data pin, pulled up when nobody drives
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_d : 1'b1);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic xfer(logic wr, logic [7:0] idx, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] idx, logic [7:0] wd);
    xfer(1'b1, idx, {24'h0, wd});
  endtask

  task automatic rd(logic [7:0] idx, logic [31:0] exp);
    expq.push_back({1'b1, exp});
    xfer(1'b0, idx, 32'h0);
  endtask

  // Poll the busy flag, queuing notes marked not to compare
  task automatic wait_idle();
    rdv = 32'h1;
    k = 0;
    // The slowest divisor keeps a frame busy for about 600 polls, so leave room for it
    while (rdv[0] !== 1'b0 && k < 1000) begin
      expq.push_back(33'h0);
      xfer(1'b0, `IDX_STATUS, 32'h0);
      k++;
    end
    check(rdv[0], 1'b0);
  endtask

  // Read monitor: oldest note against the data of each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      note = expq.pop_front();
      if (note[32]) check(prdata, note[31:0]);
    end
  end

  // Poll pulse spacing and management clock period, in pclk cycles
  always @(posedge pclk) begin
    cyc++;
    if (tx_poll_check === 1'b1) begin
      npulse++;
      gap = cyc - last_pulse;
      last_pulse = cyc;
    end
    mdc_q <= mdc;
    if (mdc && !mdc_q) begin
      mper = mcnt;
      mcnt = 1;
    end else mcnt++;
  end

  // Hang guard, well above the roughly 8500 cycles the run needs
  always @(posedge pclk) begin
    if (cyc == 60000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    {psel, penable, pwrite, tx_frame_active, presetn, mdc_q} = '0;
    paddr = '0;
    pwdata = '0;
    rd_word = '0;
    void'($urandom(17));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check(fres, 5'h1f);
    for (int i = 0; i < 7; i++) rd(8'(`IDX_WDATA_LO + i), (i == 5) ? 32'h20 : 32'h0);
    $display("test reset_values done");
    // Reserved bits and the lower bound pair
    wr(`IDX_REG_SEL, 8'hff);
    rd(`IDX_REG_SEL, 32'h1f);
    wr(`IDX_UNIT_SEL, 8'hff);
    rd(`IDX_UNIT_SEL, 32'h1f);
    wr(`IDX_TLB_LO, 8'hff);
    rd(`IDX_TLB_LO, 32'he0);
    wr(`IDX_TLB_HI, 8'hab);
    #1 check(tx_lower_bound, 16'h0be0);
    wr(8'h60, 8'h55);
    check(err_seen, 1'b1);
    rd(8'h60, 32'h0);
    $display("test field_masks done");
    // Each reset bit alone, held with no self clearing
    for (int b = 0; b < 6; b++) begin
      wr(`IDX_FRESET, 8'h01 << b);
      repeat (20) @(posedge pclk);
      #1 check(fres, (b == 5) ? 5'h1f : 5'h01 << b);
      rd(`IDX_FRESET, 32'h1 << b);
    end
    wr(`IDX_FRESET, 8'h00);
    #1 check(fres, 5'h00);
    $display("test function_resets done");
    // One frame per divisor code, odd codes read, a dropped command each time
    for (int c = 0; c < 8; c++) begin
      d = 16'($urandom);
      u = 5'($urandom);
      r = 5'($urandom);
      rd_word <= 16'($urandom);
      wr(`IDX_WDATA_LO, d[7:0]);
      wr(`IDX_WDATA_HI, d[15:8]);
      wr(`IDX_UNIT_SEL, {3'h0, u});
      wr(`IDX_REG_SEL, {3'h0, r});
      n0 = frames;
      wr(`IDX_MGMT_CMD, (c[0] ? 8'h40 : 8'h80) | 8'(c));
      wr(`IDX_MGMT_CMD, 8'h80 | 8'(c));
      wait_idle();
      repeat (2) @(posedge pclk);
      #1 check(frames, n0 + 1);
      check(frame[63:18], {32'hffff_ffff, 2'b01, c[0] ? 2'b10 : 2'b01, u, r});
      if (!c[0]) check(frame[17:0], {2'b10, d});
      else rd(`IDX_RDATA, {16'h0, rd_word});
      check(mper, per[c]);
      check({mdc, mdio_oe_n}, 2'b01);
    end
    $display("test mgmt_frames done");
    // Poll period: immediate check, period spacing, restart and stop
    n0 = npulse;
    wr(`IDX_POLL, 8'h02);
    repeat (2) @(posedge pclk);
    #1 check(npulse, n0 + 1);
    k = 0;
    while (npulse < n0 + 2 && k < 700) begin
      @(posedge pclk);
      k++;
    end
    check(gap >= 511 && gap <= 514, 1'b1);
    wr(`IDX_POLL, 8'h03);
    repeat (2) @(posedge pclk);
    #1 check(npulse, n0 + 3);
    k = 0;
    while (npulse < n0 + 4 && k < 900) begin
      @(posedge pclk);
      k++;
    end
    check(gap >= 767 && gap <= 770, 1'b1);
    rd(`IDX_STATUS, 32'h2);
    tx_frame_active <= 1'b1;
    wr(`IDX_POLL, 8'h00);
    n0 = npulse;
    repeat (800) @(posedge pclk);
    #1 check({npulse, tx_new_frame_enable}, {n0, 1'b0});
    check(tx_stopped, 1'b0);
    tx_frame_active <= 1'b0;
    @(posedge pclk);
    #1 check(tx_stopped, 1'b1);
    rd(`IDX_POLL, 32'h0);
    rd(`IDX_STATUS, 32'h0);
    $display("test poll_timer done");
    repeat (2) @(posedge pclk);
    test_done();
  end
endmodule
